// ==== igm_chk.sv ====
// Port checker for igm_top: register read port and sample path.
// Assumes one clock domain and an async active-high reset.
`default_nettype none
module igm_chk import igm_pkg::*; #(
    parameter int SW = 16
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [4:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] rdata_out,
    input wire logic signed [SW-1:0] i_in,
    input wire logic signed [SW-1:0] q_in,
    input wire logic signed [SW-1:0] i_converter_out,
    input wire logic signed [SW-1:0] q_converter_out
);
    // ------------------------------------------------------------
    // Register shadow
    // ------------------------------------------------------------
    // Quiet count after any write or stall, so the pipe holds one setting
    logic [15:0] sh_ig_q, sh_mq_q, sh_dl_q;
    logic [3:0] calm_q;
    logic [1:0] dsel;
    logic unity_ok;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sh_ig_q <= IGM_RST_IGAIN;
            sh_mq_q <= IGM_RST_MIXQ;
            sh_dl_q <= IGM_RST_DELAY;
            calm_q <= 4'h0;
        end else begin
            if (ce_in && wr_in && addr_in == IGM_ADDR_IGAIN) begin
                sh_ig_q <= wdata_in;
            end
            if (ce_in && wr_in && addr_in == IGM_ADDR_MIXQ) begin
                sh_mq_q <= wdata_in;
            end
            if (ce_in && wr_in && addr_in == IGM_ADDR_DELAY) begin
                sh_dl_q <= wdata_in;
            end
            if (!ce_in || wr_in) begin
                calm_q <= 4'h0;
            end else if (calm_q != 4'hF) begin
                calm_q <= calm_q + 4'h1;
            end
        end
    end

    assign dsel = sh_dl_q[IGM_DLY_LSB +: IGM_DLY_W];
    assign unity_ok = calm_q >= 4'h8
        && sh_ig_q[IGM_GAIN_W-1:0] == 11'h400
        && sh_mq_q[IGM_MIX_LSB +: IGM_MIX_W] == 4'h0
        && sh_mq_q[IGM_GAIN_W-1:0] == 11'h400;
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    rd_idle_a: assert property ($past(ce_in) && !$past(rd_in)
        |-> rdata_out == 16'h0000) else $error("read data not idle");
    reg_readback_a: assert property (
        (wr_in && ce_in && addr_in inside {[5'h0B:5'h0F]}) ##1
        (rd_in && ce_in && addr_in == $past(addr_in))
        |=> rdata_out == $past(wdata_in, 2)) else $error("readback");
    unmapped_rd_a: assert property (rd_in && ce_in &&
        !(addr_in inside {[5'h0B:5'h0F]}) |=> rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    zero_path_a: assert property (
        (ce_in && i_in == '0 && q_in == '0) [*8]
        |=> i_converter_out == '0 && q_converter_out == '0)
        else $error("zero input gave nonzero output");
    hold_out_a: assert property (!ce_in |=>
        $stable(i_converter_out) && $stable(q_converter_out))
        else $error("outputs moved with clock enable low");
    unity_i_a: assert property (unity_ok |->
        (dsel == 2'h0 && i_converter_out == $past(i_in, 4))
        || (dsel == 2'h1 && i_converter_out == $past(i_in, 5))
        || (dsel == 2'h2 && i_converter_out == $past(i_in, 6))
        || (dsel == 2'h3 && i_converter_out == $past(i_in, 7)))
        else $error("unity path I output wrong");
    unity_q_a: assert property (unity_ok |->
        (dsel == 2'h0 && q_converter_out == $past(q_in, 4))
        || (dsel == 2'h1 && q_converter_out == $past(q_in, 5))
        || (dsel == 2'h2 && q_converter_out == $past(q_in, 6))
        || (dsel == 2'h3 && q_converter_out == $past(q_in, 7)))
        else $error("unity path Q output wrong");
endmodule // igm_chk
bind igm_top igm_chk #(.SW(SW)) u_igm_chk (.mclk_in, .rst_in, .ce_in,
    .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .i_in, .q_in,
    .i_converter_out, .q_converter_out);
`default_nettype wire

// ==== igm_delay.sv ====
// Small delay line of up to DEPTH samples per channel, tap chosen at run time.
// Assumes the caller holds tap stable enough; a tap change takes one cycle.
`default_nettype none
module igm_delay #(
    parameter int W = 16,
    parameter int DEPTH = 3
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [1:0] tap_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] line_q [DEPTH+1];
    logic [W-1:0] line_d [DEPTH+1];
    logic [W-1:0] q_d;
    logic [W-1:0] q_q;

    always_comb begin
        line_d[0] = d_in;
        for (int i = 1; i <= DEPTH; i++) begin
            line_d[i] = line_q[i-1];
        end
        q_d = line_q[tap_in];
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i <= DEPTH; i++) begin
                line_q[i] <= '0;
            end
            q_q <= '0;
        end else if (ce_in) begin
            line_q <= line_d;
            q_q <= q_d;
        end
    end

    assign q_out = q_q;
endmodule // igm_delay
`default_nettype wire

// ==== igm_pkg.sv ====
// Constants for the IQ gain, coarse mixer and output delay register bank.
// Assumes a 16-bit register port with word addresses and one clock.
`default_nettype none
package igm_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [4:0] IGM_ADDR_RSVD_B = 5'h0B;
    localparam logic [4:0] IGM_ADDR_IGAIN = 5'h0C;
    localparam logic [4:0] IGM_ADDR_MIXQ = 5'h0D;
    localparam logic [4:0] IGM_ADDR_RSVD_E = 5'h0E;
    localparam logic [4:0] IGM_ADDR_DELAY = 5'h0F;
    localparam logic [15:0] IGM_RST_RSVD_B = 16'h0000;
    localparam logic [15:0] IGM_RST_IGAIN = 16'h0400;
    localparam logic [15:0] IGM_RST_MIXQ = 16'h0400;
    localparam logic [15:0] IGM_RST_RSVD_E = 16'h0400;
    localparam logic [15:0] IGM_RST_DELAY = 16'h0400;
    // ------------------------------------------------------------
    // Fields
    // ------------------------------------------------------------
    localparam int IGM_GAIN_W = 11;
    localparam int IGM_GAIN_FRAC = 10;
    localparam int IGM_MIX_LSB = 12;
    localparam int IGM_MIX_W = 4;
    localparam int IGM_DLY_LSB = 14;
    localparam int IGM_DLY_W = 2;
    localparam int IGM_MAX_DLY = 3;
endpackage : igm_pkg
`default_nettype wire

// ==== igm_top.sv ====
// Register bank and datapath: gain correction, coarse mixer, output delay.
// Assumes samples arrive on mclk_in, one complex sample per enabled cycle.
`default_nettype none
module igm_top import igm_pkg::*; #(
    parameter int SW = 16
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [4:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [15:0] rdata_out,
    input wire logic signed [SW-1:0] i_in,
    input wire logic signed [SW-1:0] q_in,
    output logic signed [SW-1:0] i_converter_out,
    output logic signed [SW-1:0] q_converter_out
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] rsvd_b_q;
    logic [15:0] rsvd_b_d;
    logic [15:0] igain_q;
    logic [15:0] igain_d;
    logic [15:0] mixq_q;
    logic [15:0] mixq_d;
    logic [15:0] rsvd_e_q;
    logic [15:0] rsvd_e_d;
    logic [15:0] dly_q;
    logic [15:0] dly_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;

    always_comb begin
        rsvd_b_d = rsvd_b_q;
        igain_d = igain_q;
        mixq_d = mixq_q;
        rsvd_e_d = rsvd_e_q;
        dly_d = dly_q;
        rdata_d = 16'h0000;
        if (wr_in) begin
            unique case (addr_in)
                IGM_ADDR_RSVD_B: rsvd_b_d = wdata_in;
                IGM_ADDR_IGAIN: igain_d = wdata_in;
                IGM_ADDR_MIXQ: mixq_d = wdata_in;
                IGM_ADDR_RSVD_E: rsvd_e_d = wdata_in;
                IGM_ADDR_DELAY: dly_d = wdata_in;
                default: ;
            endcase
        end
        // Unmapped addresses read as zero
        if (rd_in) begin
            unique case (addr_in)
                IGM_ADDR_RSVD_B: rdata_d = rsvd_b_q;
                IGM_ADDR_IGAIN: rdata_d = igain_q;
                IGM_ADDR_MIXQ: rdata_d = mixq_q;
                IGM_ADDR_RSVD_E: rdata_d = rsvd_e_q;
                IGM_ADDR_DELAY: rdata_d = dly_q;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rsvd_b_q <= IGM_RST_RSVD_B;
            igain_q <= IGM_RST_IGAIN;
            mixq_q <= IGM_RST_MIXQ;
            rsvd_e_q <= IGM_RST_RSVD_E;
            dly_q <= IGM_RST_DELAY;
            rdata_q <= 16'h0000;
        end else if (ce_in) begin
            rsvd_b_q <= rsvd_b_d;
            igain_q <= igain_d;
            mixq_q <= mixq_d;
            rsvd_e_q <= rsvd_e_d;
            dly_q <= dly_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata_out = rdata_q;

    // ------------------------------------------------------------
    // Gain stage
    // ------------------------------------------------------------
    localparam int PW = SW + IGM_GAIN_W + 1;
    localparam logic signed [SW-1:0] SMAX = {1'b0, {(SW-1){1'b1}}};
    localparam logic signed [SW-1:0] SMIN = {1'b1, {(SW-1){1'b0}}};
    logic signed [PW-1:0] iprod, qprod;
    logic signed [SW-1:0] ig_d, qg_d;
    logic signed [SW-1:0] ig_q, qg_q;

    // Saturate rather than wrap: gains near 2 can overflow the sample width
    function automatic logic signed [SW-1:0] sat(
        input logic signed [PW-1:0] p
    );
        logic signed [PW-1:0] s;
        s = p >>> IGM_GAIN_FRAC;
        if (s > PW'(SMAX)) begin
            sat = SMAX;
        end else if (s < PW'(SMIN)) begin
            sat = SMIN;
        end else begin
            sat = s[SW-1:0];
        end
    endfunction

    always_comb begin
        iprod = PW'(i_in) * PW'($signed({1'b0, igain_q[IGM_GAIN_W-1:0]}));
        qprod = PW'(q_in) * PW'($signed({1'b0, mixq_q[IGM_GAIN_W-1:0]}));
        ig_d = sat(iprod);
        qg_d = sat(qprod);
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ig_q <= '0;
            qg_q <= '0;
        end else if (ce_in) begin
            ig_q <= ig_d;
            qg_q <= qg_d;
        end
    end

    // ------------------------------------------------------------
    // Coarse mixer
    // ------------------------------------------------------------
    // Each stage rotates by a multiple of 45 degrees per sample; the
    // rotations add, so a phase accumulator in eighths covers all mixes.
    // Diagonal points use 1/sqrt2 approximated as 0.7071 (Q15 23170).
    localparam logic signed [17:0] HALF_RT2 = 18'sh05A82;
    logic [2:0] ph_q, ph_d, step;
    logic [IGM_MIX_W-1:0] mix;
    logic signed [SW-1:0] im_d, qm_d;
    logic signed [SW-1:0] im_q, qm_q;
    logic signed [SW+17:0] pa, pb;
    logic signed [SW:0] sa, sb;

    always_comb begin
        mix = mixq_q[IGM_MIX_LSB +: IGM_MIX_W];
        // Bit3 Fs/8, bit2 Fs/4, bit1 Fs/2, bit0 -Fs/4, in eighths
        step = (mix[3] ? 3'd1 : 3'd0) + (mix[2] ? 3'd2 : 3'd0)
             + (mix[1] ? 3'd4 : 3'd0) + (mix[0] ? 3'd6 : 3'd0);
        // With no net shift the phase parks at zero, so a bypassed mixer
        // passes samples straight through instead of a stale rotation
        if (step == 3'h0) begin
            ph_d = 3'h0;
        end else begin
            ph_d = ph_q + step;
        end
        sa = {ig_q[SW-1], ig_q} - {qg_q[SW-1], qg_q};
        sb = {ig_q[SW-1], ig_q} + {qg_q[SW-1], qg_q};
        pa = (SW+18)'(sa) * (SW+18)'(HALF_RT2);
        pb = (SW+18)'(sb) * (SW+18)'(HALF_RT2);
        unique case (ph_q)
            3'd0: begin
                im_d = ig_q;
                qm_d = qg_q;
            end
            3'd1: begin
                im_d = SW'(pa >>> 15);
                qm_d = SW'(pb >>> 15);
            end
            3'd2: begin
                im_d = -qg_q;
                qm_d = ig_q;
            end
            3'd3: begin
                im_d = SW'(-(pb >>> 15));
                qm_d = SW'(pa >>> 15);
            end
            3'd4: begin
                im_d = -ig_q;
                qm_d = -qg_q;
            end
            3'd5: begin
                im_d = SW'(-(pa >>> 15));
                qm_d = SW'(-(pb >>> 15));
            end
            3'd6: begin
                im_d = qg_q;
                qm_d = -ig_q;
            end
            3'd7: begin
                im_d = SW'(pb >>> 15);
                qm_d = SW'(-(pa >>> 15));
            end
        endcase
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ph_q <= 3'h0;
            im_q <= '0;
            qm_q <= '0;
        end else if (ce_in) begin
            ph_q <= ph_d;
            im_q <= im_d;
            qm_q <= qm_d;
        end
    end

    // ------------------------------------------------------------
    // Output delay
    // ------------------------------------------------------------
    // One shared tap keeps both converters aligned
    igm_delay #(.W(SW), .DEPTH(IGM_MAX_DLY)) u_dly_i (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .tap_in(dly_q[IGM_DLY_LSB +: IGM_DLY_W]),
        .d_in(im_q),
        .q_out(i_converter_out)
    );

    igm_delay #(.W(SW), .DEPTH(IGM_MAX_DLY)) u_dly_q (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .tap_in(dly_q[IGM_DLY_LSB +: IGM_DLY_W]),
        .d_in(qm_q),
        .q_out(q_converter_out)
    );
endmodule // igm_top
`default_nettype wire

// ==== igm_top_bench.sv ====
// Bench for igm_top: registers, gains, coarse mixer and output delay.
// Assumes igm_pkg, igm_top and igm_chk are compiled before it.
`default_nettype none
module igm_top_bench import igm_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Stimulus and checks
    // ------------------------------------------------------------
    logic mclk_in = 1'h0, rst_in = 1'h1, ce_in = 1'h1;
    logic wr_in = 1'h0, rd_in = 1'h0;
    logic [4:0] addr_in = '0;
    logic [15:0] wdata_in = '0, rdata_out;
    logic signed [15:0] i_in = '0, q_in = '0;
    logic signed [15:0] i_converter_out, q_converter_out;
    int n_mismatch = 0, n_tests = 0;
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error %0t got %h exp %h", $time, a, e); end end
    igm_top u_igm_top (.mclk_in, .rst_in, .ce_in, .addr_in, .wdata_in,
        .wr_in, .rd_in, .rdata_out, .i_in, .q_in, .i_converter_out,
        .q_converter_out);
    initial forever #2.5 mclk_in = ~mclk_in;
    // Bus tasks start just after an edge so accesses run back to back
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        wr_in <= 1'h1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge mclk_in);
        wr_in <= 1'h0;
        // Next strobe lands in a later time step, still before the next edge
        #1;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        rd_in <= 1'h1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'h0;
        #1 `CHK(rdata_out, e)
    endtask
    task automatic report_and_stop();
        $display("Checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic t_regs();
        for (int a = 11; a < 16; a++) begin
            rd(a[4:0], (a == 11) ? 16'h0000 : 16'h0400);
        end
        // A write while the clock enable is low must be lost
        ce_in <= 1'h0;
        wr(IGM_ADDR_IGAIN, 16'hFFFF);
        ce_in <= 1'h1;
        rd(IGM_ADDR_IGAIN, IGM_RST_IGAIN);
        for (int a = 11; a < 16; a++) begin
            wr(a[4:0], {a[4:0], 11'h5A5});
            rd(a[4:0], {a[4:0], 11'h5A5});
        end
        wr(5'h03, 16'hFFFF);
        rd(5'h03, 16'h0000);
        rd(5'h1F, 16'h0000);
        $display("t_regs done");
    endtask
    task automatic t_gain();
        wr(5'h0C, 16'h0200);
        wr(5'h0D, 16'h07FF);
        wr(5'h0F, 16'h0400);
        i_in <= 16'h03E8;
        q_in <= 16'h03E8;
        repeat (10) @(posedge mclk_in);
        #1 `CHK(i_converter_out, 16'h01F4)
        `CHK(q_converter_out, 16'h07CF)
        $display("t_gain done");
    endtask
    task automatic t_delay();
        int n;
        wr(5'h0C, 16'h0400);
        wr(5'h0D, 16'h0400);
        for (int d = 0; d < 4; d++) begin
            i_in <= '0;
            q_in <= '0;
            wr(5'h0F, {d[1:0], 14'h0400});
            repeat (10) @(posedge mclk_in);
            i_in <= 16'h03E8;
            n = 0;
            do begin
                @(posedge mclk_in);
                n++;
                #1;
            end while (i_converter_out !== 16'h03E8 && n < 20);
            `CHK(n, 4 + d)
            if (n >= 20) report_and_stop();
        end
        $display("t_delay done");
    endtask
    // Even shifts are checked exactly; odd ones use diagonal
    // coefficients whose rounding is loose, so only the half turn
    task automatic t_mix();
        logic signed [15:0] ia [12], qa [12], ei, eq, t;
        int s;
        wr(5'h0F, 16'h0400);
        i_in <= 16'h03E8;
        q_in <= '0;
        for (int m = 0; m < 16; m++) begin
            wr(5'h0D, {m[3:0], 12'h400});
            repeat (8) @(posedge mclk_in);
            for (int k = 0; k < 12; k++) begin
                @(posedge mclk_in);
                #1 ia[k] = i_converter_out;
                qa[k] = q_converter_out;
            end
            s = (m[3] + 2 * m[2] + 4 * m[1] + 6 * m[0]) % 8;
            for (int k = 0; k < 8; k++) begin
                ei = ia[k];
                eq = qa[k];
                repeat (s / 2) begin
                    t = ei;
                    ei = -eq;
                    eq = t;
                end
                if (s % 2 == 0) begin
                    `CHK(ia[k+1], ei)
                    `CHK(qa[k+1], eq)
                end else `CHK(ia[k] + ia[k+4] inside {[-2:2]}, 1'h1)
            end
        end
        // Rotating I output must hold while the clock enable is low
        wr(IGM_ADDR_MIXQ, 16'h4400);
        repeat (8) @(posedge mclk_in);
        ce_in <= 1'h0;
        #1 ei = i_converter_out;
        repeat (3) @(posedge mclk_in);
        #1 `CHK(i_converter_out, ei)
        ce_in <= 1'h1;
        $display("t_mix done");
    endtask
    initial begin
        repeat (8) @(posedge mclk_in);
        rst_in <= 1'h0;
        t_regs();
        t_gain();
        t_delay();
        t_mix();
        report_and_stop();
    end
endmodule // igm_top_bench
`default_nettype wire
